/* File: rtl/logic_tile_datapath.sv */
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "tile_map.svh"
module logic_tile_datapath (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire tile_pkg::avs_req_t avs_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [5:0] route_in,
    output logic [5:0] route_out,
    output logic [7:0] ctrl_out,
    input wire logic [7:0] status_in,
    input wire tile_pkg::chain_t chain_in,
    output tile_pkg::chain_t chain_out,
    output logic [7:0] par_data_out,
    output logic par_valid_out,
    input wire logic par_ready_in
);
    import tile_pkg::*;

    // Bus and register state
    bus_state_t state, next_state;
    logic [31:0] next_rdata;
    logic next_wait;
    logic [7:0] next_ctrl;
    logic [7:0] latch_mask, next_latch_mask; // Bits that latch
    logic [7:0] lat, next_lat;               // Latched status
    logic [7:0] lat_snap, next_lat_snap;     // Latched bits read
    logic [6:0] mode, next_mode;
    logic [23:0] osel, next_osel;            // Output selects
    logic acc_go, wr_go, rd_go;
    logic [7:0] st_view;
    logic [1:0] dir;                         // 1 = output buffer

    // Datapath state
    logic [1:0][7:0] acc, next_acc;
    logic [1:0][7:0] dreg, next_dreg;
    fifo_t [1:0] fifo, next_fifo;
    logic carry_q, next_carry;
    logic shift_q, next_shift;
    logic [7:0] buf_tail, next_buf_tail;     // Second buffer entry
    logic [1:0] buf_cnt, next_buf_cnt;
    logic [7:0] next_par_data;
    logic [5:0] next_route;
    chain_t next_chain;
    cfg_word_t cw;

    // Datapath combinational helpers
    logic run, cfg_wr;
    logic [7:0] op_a, op_b, op_bb, res;
    logic [8:0] sum;
    logic cin, sin, sout, ovf;
    logic [1:0] bus_push, bus_pop, dp_go;
    logic [15:0] cond;

    assign dir = mode[`M_DIR];
    assign acc_go = (state == BUS_ACK);
    assign wr_go = acc_go && avs_in.write;
    assign rd_go = acc_go && avs_in.read;
    assign cfg_wr = wr_go && (avs_in.address[`ADDR_HI] == `CFG_HI);
    // Masked bits show the latch, others the live status level
    assign st_view = (lat & latch_mask) | (status_in & ~latch_mask);

    cfg_ram u_cfg_ram (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(cfg_wr),
        .wr_addr_in(avs_in.address[`ADDR_WORD]),
        .wr_data_in(cfg_word_t'(avs_in.writedata[15:0])),
        .rd_addr_in(route_in[`RIN_ADDR]),
        .rd_data_out(cw)
    );

    // Bus slave and firmware registers
    always_comb begin
        next_state = state;
        next_rdata = avs_readdata_out;
        next_ctrl = ctrl_out;
        next_latch_mask = latch_mask;
        next_mode = mode;
        next_osel = osel;
        next_lat_snap = lat_snap;
        case (state)
            BUS_IDLE: begin
                if (avs_in.read || avs_in.write) begin
                    next_state = BUS_ACK;
                end
            end
            BUS_ACK: begin
                next_state = BUS_IDLE;
            end
            default: begin
                next_state = BUS_IDLE;
            end
        endcase
        next_wait = (next_state != BUS_ACK);
        // Read data captured one edge ahead of the answer
        if (state == BUS_IDLE && avs_in.read) begin
            next_lat_snap = '0;
            case (avs_in.address)
                `OFF_CTRL: next_rdata = 32'(ctrl_out);
                `OFF_STATUS: begin
                    next_rdata = 32'(st_view);
                    next_lat_snap = lat & latch_mask;
                end
                `OFF_LATCH: next_rdata = 32'(latch_mask);
                `OFF_MODE: next_rdata = 32'(mode);
                `OFF_OSEL: next_rdata = 32'(osel);
                `OFF_FSTAT: next_rdata = 32'({fifo[1].cnt, fifo[0].cnt});
                `OFF_FIFO0: next_rdata = dir[0] ?
                    32'(fifo[0].mem[fifo[0].rd]) : '0;
                `OFF_FIFO1: next_rdata = dir[1] ?
                    32'(fifo[1].mem[fifo[1].rd]) : '0;
                `OFF_D0: next_rdata = 32'(dreg[0]);
                `OFF_D1: next_rdata = 32'(dreg[1]);
                `OFF_A0: next_rdata = 32'(acc[0]);
                `OFF_A1: next_rdata = 32'(acc[1]);
                default: next_rdata = '0;
            endcase
        end
        if (wr_go) begin
            case (avs_in.address)
                `OFF_CTRL: next_ctrl = avs_in.writedata[7:0];
                `OFF_LATCH: next_latch_mask = avs_in.writedata[7:0];
                `OFF_MODE: next_mode = avs_in.writedata[6:0];
                `OFF_OSEL: next_osel = avs_in.writedata[23:0];
                default: next_osel = osel;
            endcase
        end
        // Clear only bits that were read; a fresh set wins
        next_lat = lat & ~((rd_go &&
            avs_in.address == `OFF_STATUS) ? lat_snap : 8'h00);
        if (mode[`M_SCEN]) begin
            next_lat = next_lat | (status_in & latch_mask);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= BUS_IDLE;
            avs_readdata_out <= '0;
            avs_waitrequest_out <= 1'b1;
            ctrl_out <= `RST_CTRL;
            latch_mask <= `RST_LATCH;
            lat <= '0;
            lat_snap <= '0;
            mode <= `RST_MODE;
            osel <= `RST_OSEL;
        end else begin
            state <= next_state;
            avs_readdata_out <= next_rdata;
            avs_waitrequest_out <= next_wait;
            ctrl_out <= next_ctrl;
            latch_mask <= next_latch_mask;
            lat <= next_lat;
            lat_snap <= next_lat_snap;
            mode <= next_mode;
            osel <= next_osel;
        end
    end

    // Datapath, FIFOs, buffer and routed outputs
    always_comb begin
        next_acc = acc;
        next_dreg = dreg;
        next_carry = carry_q;
        next_shift = shift_q;
        // Full parallel buffer stalls the whole datapath step when that step emits
        run = mode[`M_DPEN] && !(cw.emit && buf_cnt == `BUF_FULL);
        op_a = cw.srca_a1 ? acc[1] : acc[0];
        op_b = cw.srcb_d1 ? dreg[1] : dreg[0];
        op_bb = (cw.op == OP_SUB) ? ~op_b : op_b;
        cin = cw.cin_reg ? carry_q :
            (mode[`M_CHC] && chain_in.carry);
        case (cw.op)
            OP_INC: sum = {1'b0, op_a} + 9'h001;
            OP_DEC: sum = {1'b0, op_a} - 9'h001;
            OP_ADD: sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
            OP_SUB: sum = {1'b0, op_a} + {1'b0, op_bb} + 9'h001;
            OP_AND: sum = {1'b0, op_a & op_b};
            OP_OR: sum = {1'b0, op_a | op_b};
            OP_XOR: sum = {1'b0, op_a ^ op_b};
            default: sum = {1'b0, op_a};
        endcase
        ovf = (cw.op == OP_ADD || cw.op == OP_SUB) &&
            (op_a[7] == op_bb[7]) && (sum[7] != op_a[7]);
        sin = cw.shin_reg ? shift_q : (mode[`M_CHS] ? chain_in.shift :
            route_in[`RIN_SIN]);
        case (cw.shift)
            SH_LEFT: begin
                res = {sum[6:0], sin};
                sout = sum[7];
            end
            SH_RIGHT: begin
                res = {sin, sum[7:1]};
                sout = sum[0];
            end
            SH_SWAP: begin
                res = {sum[3:0], sum[7:4]};
                sout = 1'b0;
            end
            default: begin
                res = sum[7:0];
                sout = sum[7];
            end
        endcase
        if (run) begin
            if (cw.wr_a0) begin
                next_acc[0] = res;
            end
            if (cw.wr_a1) begin
                next_acc[1] = res;
            end
            next_carry = sum[8];
            next_shift = sout;
        end
        // Bus fills input FIFOs and drains output FIFOs
        bus_push[0] = wr_go && avs_in.address == `OFF_FIFO0 && !dir[0];
        bus_push[1] = wr_go && avs_in.address == `OFF_FIFO1 && !dir[1];
        bus_pop[0] = rd_go && avs_in.address == `OFF_FIFO0 && dir[0];
        bus_pop[1] = rd_go && avs_in.address == `OFF_FIFO1 && dir[1];
        dp_go = run ? {cw.fifo1_go, cw.fifo0_go} : 2'b00;
        for (int i = 0; i < 2; i++) begin
            // Direction of each FIFO set on its own
            next_fifo[i] = fifo_step(fifo[i],
                bus_push[i] || (dp_go[i] && dir[i]),
                bus_pop[i] || (dp_go[i] && !dir[i]),
                dir[i] ? (cw.cap_alu ? res : acc[i])
                       : avs_in.writedata[7:0]);
            if (dp_go[i] && !dir[i] && fifo[i].cnt != 3'h0) begin
                if (cw.load_d) begin
                    next_dreg[i] = fifo[i].mem[fifo[i].rd];
                end else begin
                    next_acc[i] = fifo[i].mem[fifo[i].rd];
                end
            end
        end
        if (wr_go && avs_in.address == `OFF_D0) begin
            next_dreg[0] = avs_in.writedata[7:0];
        end
        if (wr_go && avs_in.address == `OFF_D1) begin
            next_dreg[1] = avs_in.writedata[7:0];
        end
        // Two-entry buffer: head is the output register itself
        next_par_data = par_data_out;
        next_buf_tail = buf_tail;
        next_buf_cnt = buf_cnt;
        if (par_valid_out && par_ready_in) begin
            next_par_data = buf_tail;
            next_buf_cnt = buf_cnt - 2'h1;
        end
        if (run && cw.emit) begin
            if (next_buf_cnt == 2'h0) begin
                next_par_data = res;
            end else begin
                next_buf_tail = res;
            end
            next_buf_cnt = next_buf_cnt + 2'h1;
        end
        // Conditions taken from next state so flags track each access
        cond = '0;
        cond[0] = (next_acc[0] == next_dreg[0]) &&
            (!mode[`M_CHQ] || chain_in.cond);
        cond[1] = next_acc[1] < next_dreg[1];
        cond[2] = next_acc[0] == '0;
        cond[3] = next_acc[1] == '0;
        cond[4] = next_acc[0] == '1;
        cond[5] = next_acc[1] == '1;
        cond[6] = run && ovf;
        cond[7] = next_shift;
        cond[8] = next_fifo[0].cnt == 3'h0;
        cond[9] = next_fifo[0].cnt == `FIFO_DEPTH;
        cond[10] = next_fifo[1].cnt == 3'h0;
        cond[11] = next_fifo[1].cnt == `FIFO_DEPTH;
        cond[12] = next_carry;
        cond[13] = route_in[`RIN_AUX];
        for (int j = 0; j < 6; j++) begin
            next_route[j] = cond[osel[j*`OSEL_W +: `OSEL_W]];
        end
        next_chain = '{carry: next_carry, shift: next_shift,
            cond: cond[0]};
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc <= '0;
            dreg <= '0;
            fifo <= '0;
            carry_q <= 1'b0;
            shift_q <= 1'b0;
            buf_tail <= '0;
            buf_cnt <= 2'h0;
            par_data_out <= '0;
            par_valid_out <= 1'b0;
            route_out <= '0;
            chain_out <= '0;
        end else begin
            acc <= next_acc;
            dreg <= next_dreg;
            fifo <= next_fifo;
            carry_q <= next_carry;
            shift_q <= next_shift;
            buf_tail <= next_buf_tail;
            buf_cnt <= next_buf_cnt;
            par_data_out <= next_par_data;
            par_valid_out <= (next_buf_cnt != 2'h0);
            route_out <= next_route;
            chain_out <= next_chain;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_bus_req;
        state == BUS_IDLE && (avs_in.read || avs_in.write);
    endsequence
    sequence s_bus_done;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    a_bus_answer: assert property (s_bus_req |=> s_bus_done)
        else $error("bus answer not one wait state");
    a_fifo_bound: assert property (
        fifo[0].cnt <= `FIFO_DEPTH && fifo[1].cnt <= `FIFO_DEPTH)
        else $error("fifo count above depth");
    a_full_push: assert property (
        fifo[0].cnt == `FIFO_DEPTH && bus_push[0] |=> $stable(fifo[0].wr))
        else $error("push into full fifo moved pointer");
    a_dir_block: assert property (
        wr_go && avs_in.address == `OFF_FIFO1 && dir[1] && !dp_go[1]
        |=> fifo[1].cnt <= $past(fifo[1].cnt))
        else $error("bus wrote an output fifo");
    a_ctrl_drive: assert property (
        wr_go && avs_in.address == `OFF_CTRL
        |=> ctrl_out == $past(avs_in.writedata[7:0]))
        else $error("control bits not driven");
    a_latch_keep: assert property (
        !rd_go && mode[`M_SCEN] |=> ($past(lat) & ~lat) == 8'h00 &&
        ($past(status_in & latch_mask) & ~lat) == 8'h00)
        else $error("latched status lost without read");
    a_carry_reg: assert property (
        run |=> carry_q == $past(sum[8]) && shift_q == $past(sout))
        else $error("carry or shift not registered");
    a_route_sel: assert property (
        1'b1 |=> route_out[0] == $past(cond[osel[3:0]]))
        else $error("routed output not from selected condition");
    a_empty_flag: assert property (
        osel[3:0] == 4'h8 && $past(osel[3:0]) == 4'h8
        |-> route_out[0] == (fifo[0].cnt == 3'h0))
        else $error("empty flag lags fifo count");
    a_buf_stall: assert property (
        buf_cnt == `BUF_FULL && cw.emit |-> !run ##1 buf_cnt != 2'h0)
        else $error("full buffer did not stall datapath");
endmodule

/* File: rtl/tile_map.svh */
`ifndef TILE_MAP_SVH
`define TILE_MAP_SVH

// Register byte offsets on the Avalon slave
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_LATCH 8'h08
`define OFF_MODE 8'h0C
`define OFF_OSEL 8'h10
`define OFF_FSTAT 8'h14
`define OFF_FIFO0 8'h18
`define OFF_FIFO1 8'h1C
`define OFF_D0 8'h20
`define OFF_D1 8'h24
`define OFF_A0 8'h28
`define OFF_A1 8'h2C
// Config memory window: address[7:5] == CFG_HI, word = address[4:2]
`define CFG_HI 3'h2
`define ADDR_HI 7:5
`define ADDR_WORD 4:2

// Mode register fields
`define M_DIR 1:0
`define M_CHC 2
`define M_CHS 3
`define M_CHQ 4
`define M_DPEN 5
`define M_SCEN 6

// Reset values
`define RST_CTRL 8'h00
`define RST_LATCH 8'h00
`define RST_MODE 7'h60
`define RST_OSEL 24'h00_0000

// Routed input fields
`define RIN_ADDR 2:0
`define RIN_SIN 3
`define RIN_AUX 4

// Sizes
`define FIFO_DEPTH 3'h4
`define OSEL_W 4
`define BUF_FULL 2'h2

`endif

/* File: rtl/tile_pkg.sv */
package tile_pkg;
`include "tile_map.svh"

    // ALU functions
    typedef enum logic [2:0] {
        OP_INC = 3'h0, OP_DEC = 3'h1, OP_ADD = 3'h2, OP_SUB = 3'h3,
        OP_AND = 3'h4, OP_OR = 3'h5, OP_XOR = 3'h6, OP_PASS = 3'h7
    } alu_op_t;

    // Shifter functions
    typedef enum logic [1:0] {
        SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3
    } shift_t;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    // One 16-bit per-cycle configuration word
    typedef struct packed {
        logic load_d;    // Input FIFO loads data reg, else accumulator
        logic cap_alu;   // Output FIFO takes ALU result, else accumulator
        logic emit;      // Push ALU result into parallel buffer
        logic fifo1_go;  // Datapath pops or pushes second FIFO
        logic fifo0_go;  // Datapath pops or pushes first FIFO
        logic shin_reg;  // Shift-in from registered shift-out
        logic cin_reg;   // Carry-in from registered carry
        shift_t shift;
        logic wr_a1;
        logic wr_a0;
        logic srcb_d1;   // B operand from second data reg
        logic srca_a1;   // A operand from second accumulator
        alu_op_t op;
    } cfg_word_t;

    // Four-byte FIFO state
    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [1:0] rd;
        logic [1:0] wr;
        logic [2:0] cnt;
    } fifo_t;

    // Neighbour chaining signals
    typedef struct packed {
        logic carry;
        logic shift;
        logic cond;
    } chain_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } avs_req_t;

    // Push into full or pop from empty leaves the FIFO untouched
    function automatic fifo_t fifo_step(fifo_t f, logic push, logic pop,
                                        logic [7:0] din);
        fifo_t n;
        logic do_push;
        logic do_pop;
        n = f;
        do_push = push && (f.cnt != `FIFO_DEPTH);
        do_pop = pop && (f.cnt != 3'h0);
        if (do_push) begin
            n.mem[f.wr] = din;
            n.wr = f.wr + 2'h1;
        end
        if (do_pop) begin
            n.rd = f.rd + 2'h1;
        end
        n.cnt = f.cnt + {2'h0, do_push} - {2'h0, do_pop};
        return n;
    endfunction

endpackage

/* File: rtl/cfg_ram.sv */
`timescale 1ns/1ns
module cfg_ram (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_addr_in,
    input wire tile_pkg::cfg_word_t wr_data_in,
    input wire logic [2:0] rd_addr_in,
    output tile_pkg::cfg_word_t rd_data_out
);
    import tile_pkg::*;

    cfg_word_t mem [8];      // Eight configuration words
    cfg_word_t next_mem [8];
    cfg_word_t next_rd;

    // Write port from the bus, read port from the routing
    always_comb begin
        next_mem = mem;
        if (wr_en_in) begin
            next_mem[wr_addr_in] = wr_data_in;
        end
        next_rd = mem[rd_addr_in];
    end

    // Array cleared too, so an unwritten word reads as an idle step
    // and no unknown leaks into the datapath before firmware loads it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem <= '{default: '0};
            rd_data_out <= '0;
        end else begin
            mem <= next_mem;
            rd_data_out <= next_rd;
        end
    end

    a_cfg_read: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !$past(wr_en_in) |-> rd_data_out == $past(mem[rd_addr_in]))
        else $error("config word not read from addressed entry");
endmodule

/* File: verif/par_sink.sv */
`timescale 1ns/1ns
// Receiver on the parallel buffer side, slow on purpose
module par_sink (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] data_in,
    input wire logic valid_in,
    output logic ready_out,
    output logic [7:0] count_out,
    output logic [7:0] bad_out
);
    logic [1:0] phase; // Stall pattern step
    logic [7:0] last; // Byte taken before
    // Ready one cycle in three, so the buffer fills and stalls the tile
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase <= 2'h0;
            ready_out <= 1'b0;
            count_out <= 8'h00;
            bad_out <= 8'h00;
            last <= 8'h00;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            ready_out <= (phase == 2'h1);
            // Take a byte, each must follow the one before
            if (valid_in && ready_out) begin
                count_out <= count_out + 8'h01;
                last <= data_in;
                if (count_out != 8'h00 && data_in !== last + 8'h01) begin
                    bad_out <= bad_out + 8'h01;
                end
            end
        end
    end
endmodule

/* File: verif/logic_tile_datapath_fifo_status_ctrl_tb.sv */
`timescale 1ns/1ns
`include "tile_map.svh"
module logic_tile_datapath_fifo_status_ctrl_tb;
    import tile_pkg::*;
    logic clk_in = 1'b0; // 10 MHz bench clock
    logic rst_n_in; // Active low reset
    avs_req_t avs; // Bus request
    logic [31:0] rdata; // Bus read data
    logic waitreq; // Bus wait
    logic [5:0] route_in; // Routed inputs
    logic [5:0] route_out; // Routed outputs
    logic [7:0] ctrl_out; // Control bits
    logic [7:0] status_in; // Status levels
    chain_t chain_in; // Neighbour chain, tied quiet
    chain_t chain_out; // Neighbour chain out
    logic [7:0] par_data; // Buffer head
    logic par_valid; // Buffer valid
    logic par_ready; // Receiver ready
    logic [7:0] sink_count; // Bytes taken
    logic [7:0] sink_bad; // Bytes out of order
    logic [31:0] q; // Last read data
    int n_errors = 0; // Mismatches
    int compares = 0; // Comparisons made
    // Config words: idle, pop to data reg, inc and emit, pop to acc
    logic [15:0] cfg [8] = '{16'h0000, 16'h8800, 16'h2020, 16'h0800,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Clock
    always #50 clk_in = ~clk_in;

    logic_tile_datapath dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_in(avs),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .route_in(route_in), .route_out(route_out), .ctrl_out(ctrl_out),
        .status_in(status_in), .chain_in(chain_in), .chain_out(chain_out),
        .par_data_out(par_data), .par_valid_out(par_valid),
        .par_ready_in(par_ready)
    );
    par_sink sink_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .data_in(par_data),
        .valid_in(par_valid), .ready_out(par_ready),
        .count_out(sink_count), .bad_out(sink_bad)
    );

    // One comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs.read <= !wr;
        avs.write <= wr;
        avs.address <= a;
        avs.writedata <= d;
        // Hold until waitrequest is seen low, bounded
        do begin
            @(posedge clk_in);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        avs.read <= 1'b0;
        avs.write <= 1'b0;
        // Gap edge so the strobe is never driven twice in one step
        @(posedge clk_in);
        if (n == 20) chk("waitrequest", 32'h0, 32'h1);
    endtask

    // Read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, q);
    endtask

    // Counts, then verdict
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        end_of_test();
    end

    // Main sequence
    initial begin
        avs = '0;
        route_in = 6'h00;
        status_in = 8'h00;
        chain_in = '0;
        rst_n_in = 1'b0;
        repeat (6) @(posedge clk_in);
        chk("waitrequest", 32'h1, {31'h0, waitreq});
        chk("ctrl_out", 32'h0, {24'h0, ctrl_out});
        chk("par_valid", 32'h0, {31'h0, par_valid});
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        // Stop the datapath before its config memory is written
        bus(1'b1, `OFF_MODE, 32'h0000_0040);
        rd_chk(`OFF_OSEL, 32'h0000_0000, "osel");
        $display("test reset done");
        bus(1'b1, `OFF_CTRL, 32'h0000_00A5);
        chk("ctrl_out", 32'h0000_00A5, {24'h0, ctrl_out});
        rd_chk(`OFF_CTRL, 32'h0000_00A5, "ctrl");
        $display("test control done");
        // Bit 0 latched, bit 1 live; a one-cycle pulse must be held
        bus(1'b1, `OFF_LATCH, 32'h0000_0001);
        status_in <= 8'h03;
        @(posedge clk_in);
        status_in <= 8'h02;
        @(posedge clk_in);
        bus(1'b1, `OFF_STATUS, 32'h0000_00FF);
        rd_chk(`OFF_STATUS, 32'h0000_0003, "status");
        rd_chk(`OFF_STATUS, 32'h0000_0002, "status");
        $display("test status done");
        // Outputs 0..2 show fifo0 empty, fifo0 full, aux input
        route_in <= 6'h10;
        bus(1'b1, `OFF_OSEL, 32'h0000_0D98);
        for (int i = 1; i <= 5; i++) begin
            bus(1'b1, `OFF_FIFO0, 32'h11 * i);
        end
        rd_chk(`OFF_FSTAT, 32'h0000_0004, "fstat");
        chk("route_out", 32'h6, {29'h0, route_out[2:0]});
        rd_chk(`OFF_FIFO0, 32'h0000_0000, "fifo0 read");
        bus(1'b1, `OFF_MODE, 32'h0000_0042);
        bus(1'b1, `OFF_FIFO1, 32'h0000_0077);
        rd_chk(`OFF_FSTAT, 32'h0000_0004, "fstat");
        $display("test fifo fill done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h40 + 8'(4 * i), {16'h0000, cfg[i]});
        end
        // Word 1 drains fifo0 into the first data register
        route_in <= 6'h11;
        bus(1'b1, `OFF_MODE, 32'h0000_0060);
        repeat (10) @(posedge clk_in);
        rd_chk(`OFF_FSTAT, 32'h0000_0000, "fstat");
        rd_chk(`OFF_D0, 32'h0000_0044, "data reg");
        chk("route_out", 32'h5, {29'h0, route_out[2:0]});
        $display("test fifo drain done");
        // Word 3 loads the accumulator, word 2 counts and emits
        route_in <= 6'h13;
        bus(1'b1, `OFF_FIFO0, 32'h0000_0005);
        repeat (4) @(posedge clk_in);
        rd_chk(`OFF_A0, 32'h0000_0005, "accumulator");
        route_in <= 6'h12;
        repeat (40) @(posedge clk_in);
        route_in <= 6'h10;
        repeat (20) @(posedge clk_in);
        rd_chk(`OFF_A0, {24'h0, 8'h05 + sink_count}, "accumulator");
        chk("order", 32'h0, {24'h0, sink_bad});
        chk("emitted", 32'h1, {31'h0, sink_count > 8'h05});
        $display("test emit done");
        // Word 4 passes the first accumulator into the output fifo
        bus(1'b1, 8'h50, 32'h0000_5007);
        bus(1'b1, `OFF_MODE, 32'h0000_0062);
        route_in <= 6'h14;
        repeat (8) @(posedge clk_in);
        route_in <= 6'h10;
        rd_chk(`OFF_FSTAT, 32'h0000_0020, "fstat");
        rd_chk(`OFF_FIFO1, {24'h0, 8'h05 + sink_count}, "fifo1");
        rd_chk(`OFF_FSTAT, 32'h0000_0018, "fstat");
        chk("chain_out", 32'h0, {29'h0, chain_out});
        $display("test output fifo done");
        rd_chk(8'h30, 32'h0000_0000, "unmapped");
        rd_chk(8'h40, 32'h0000_0000, "config read");
        $display("test refusals done");
        end_of_test();
    end
endmodule
